// [sfh_host_ctrl.sv]
// Purpose: APB-driven host controller framing serial flash commands
// Assumes: flash in SPI mode 0; software polls STAT for data flags
// Notes: mode flags are the host's shadow of the device's state
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module sfh_host_ctrl
  import sfh_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYC
)
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic flash_cs_b_out,
  output wire logic flash_sck_out,
  output logic [3:0] flash_dq_out,
  output logic [3:0] flash_dq_oe_b_out,
  input wire logic [3:0] flash_dq_in
);
  sfh_state_e st_reg;
  sfh_phase_e ph_reg;
  logic [15:0] tmr_reg;
  logic go_reg, err_reg, run_reg, wait_reg, rd_took_reg;
  logic [2:0] rec_reg;
  logic [23:0] addr_reg;
  logic [15:0] len_reg;
  logic [2:0] cfg_reg;
  logic [7:0] cmd_op_reg, op_q_reg;
  logic arm_reg, qpi_reg, crm_reg, wel_reg, vsr_reg;
  logic [2:0] cw_reg, aw_reg, dw_reg, w_reg;
  logic [4:0] dum_reg, cnt_reg, en_reg;
  logic rd_q_reg, rel_reg, crm_req_reg;
  logic [31:0] sh_reg;
  logic [7:0] rx_reg, rdata_reg, wd_reg;
  logic rd_valid_reg, wd_full_reg;
  logic [15:0] bytes_reg;
  logic sck_rise, sck_fall;
  logic [3:0] dq_s;

  logic apb_setup, apb_wr, apb_rd, busy, start, launch, refuse_evt;
  logic adv, stall, end_frame, frame_done;
  logic [7:0] d_op;
  logic [2:0] d_cw, d_aw, d_dw;
  logic [4:0] d_dum, d_en, above, nxt;
  logic [5:0] low_t;
  logic d_skip, d_aon, d_mon, d_rd, d_refuse;
  logic [15:0] d_len;
  logic [7:0] rx_next;

  sfh_sync #(.W(4)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .async_in(flash_dq_in),
    .sync_out(dq_s)
  );

  sfh_sck_div #(.HALF(SCK_HALF)) u_div (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .run_in(run_reg),
    .sck_out(flash_sck_out),
    .rise_out(sck_rise),
    .fall_out(sck_fall)
  );

  assign apb_setup = psel_in & ~penable_in;
  assign apb_wr = psel_in & penable_in & pready_out & pwrite_in;
  assign apb_rd = psel_in & penable_in & pready_out & ~pwrite_in;
  assign busy = (st_reg != ST_IDLE) | go_reg | (rec_reg != 3'd0);
  assign start = (st_reg == ST_IDLE) & (go_reg | (rec_reg != 3'd0));
  assign launch = start & ~d_refuse;
  assign refuse_evt = start & d_refuse;
  assign frame_done = (st_reg == ST_HOLD) & (tmr_reg == 16'h0000);

  // command decode from opcode and current shadow mode
  always_comb
  begin
    d_op = cmd_op_reg;
    d_cw = qpi_reg ? 3'd4 : 3'd1;
    d_aw = d_cw;
    d_dw = d_cw;
    d_skip = 1'b0;
    d_aon = 1'b0;
    d_mon = 1'b0;
    d_dum = 5'd0;
    d_rd = 1'b1;
    d_len = len_reg;
    d_refuse = 1'b0;
    if (rec_reg != 3'd0)
    begin
      d_op = rec_reg[0] ? OP_RESET_ARM : OP_RESET;
      d_cw = (rec_reg <= 3'd2) ? 3'd4 : 3'd1;
      d_len = 16'h0000;
    end
    else
    begin
      case (cmd_op_reg)
        OP_READ, OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT:
        begin
          d_refuse = qpi_reg;
          d_aon = 1'b1;
          if (cmd_op_reg == OP_DUAL_OUT)
          begin
            d_dum = FAST_DUMMY_CLK;
            d_dw = 3'd2;
          end
          else if (cmd_op_reg == OP_DUAL_IO)
          begin
            d_aw = 3'd2;
            d_dum = DUAL_IO_DUMMY_CLK;
            d_dw = 3'd2;
          end
          else if (cmd_op_reg == OP_QUAD_OUT)
          begin
            d_dum = FAST_DUMMY_CLK;
            d_dw = 3'd4;
          end
        end
        OP_FAST:
        begin
          d_aon = 1'b1;
          d_dum = qpi_reg ? sr3_dummy(cfg_reg[1:0]) : FAST_DUMMY_CLK;
        end
        OP_QUAD_IO:
        begin
          d_skip = crm_reg;
          d_aon = 1'b1;
          d_aw = 3'd4;
          d_mon = 1'b1;
          // configured count includes the two mode clocks
          d_dum = sr3_dummy(cfg_reg[1:0]) - MODE_CLK;
          d_dw = 3'd4;
        end
        OP_PROG, OP_QPROG:
        begin
          d_aon = 1'b1;
          d_rd = 1'b0;
          d_dw = (cmd_op_reg == OP_QPROG) ? 3'd4 : d_cw;
          d_refuse = ~wel_reg;
        end
        OP_SECT_ER, OP_HALF_ER, OP_BLK_ER, OP_CHIP_ER1, OP_CHIP_ER2:
        begin
          d_aon = (cmd_op_reg != OP_CHIP_ER1) & (cmd_op_reg != OP_CHIP_ER2);
          d_len = 16'h0000;
          d_refuse = ~wel_reg;
        end
        OP_STAT_WR, OP_STAT3_WR:
        begin
          d_rd = 1'b0;
          d_refuse = ~(wel_reg | (vsr_reg & (cmd_op_reg == OP_STAT_WR)));
        end
        OP_QUAD_EXIT, OP_RESET_ARM, OP_RESET:
        begin
          d_len = 16'h0000;
          d_cw = (qpi_reg | crm_reg) ? 3'd4 : 3'd1;
        end
        OP_ID_RES, OP_ID_MFR:
          d_aon = 1'b1;
        default:
          d_rd = 1'b1;
      endcase
      if (crm_reg & ~((cmd_op_reg == OP_QUAD_IO) | (cmd_op_reg == OP_QUAD_EXIT)
          | (cmd_op_reg == OP_RESET_ARM) | (cmd_op_reg == OP_RESET)))
        d_refuse = 1'b1;
    end
    d_en = {d_len != 16'h0000, d_dum != 5'd0, d_mon, d_aon, ~d_skip};
  end

  // next enabled phase after the current one
  always_comb
  begin
    low_t = {5'(ph_reg), 1'b0} - 6'd1;
    above = (ph_reg == PH_NONE) ? en_reg : (en_reg & ~low_t[4:0]);
    nxt = above & (~above + 5'd1);
    adv = ((st_reg == ST_SETUP) & (tmr_reg == 16'h0000))
          | ((st_reg == ST_SHIFT) & (sck_fall | wait_reg));
    stall = 1'b0;
    end_frame = 1'b0;
    if (cnt_reg != 5'd0)
      stall = (ph_reg == PH_DATA) & rd_q_reg & (cnt_reg == 5'd1) & rd_valid_reg;
    else if ((ph_reg == PH_DATA) & (bytes_reg > 16'h0001))
      stall = ~rd_q_reg & ~wd_full_reg;
    else if (nxt == 5'd0)
      end_frame = 1'b1;
    else
      stall = (nxt == 5'(PH_DATA)) & ~rd_q_reg & ~wd_full_reg;
    case (w_reg)
      3'd4: rx_next = {rx_reg[3:0], dq_s};
      3'd2: rx_next = {rx_reg[5:0], dq_s[1:0]};
      default: rx_next = {rx_reg[6:0], dq_s[1]};
    endcase
  end

  // frame sequencing
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      st_reg <= ST_IDLE;
      tmr_reg <= 16'h0000;
      flash_cs_b_out <= 1'b1;
      rec_reg <= 3'd0;
    end
    else
    begin
      case (st_reg)
        ST_IDLE:
          if (launch)
          begin
            st_reg <= ST_SETUP;
            flash_cs_b_out <= 1'b0;
            tmr_reg <= 16'(CS_SETUP_CYC);
          end
          else if (apb_wr & (paddr_in == REG_CMD) & ~busy
                   & pwdata_in[CMD_RECOVER_BIT])
            rec_reg <= 3'd1;
        ST_SETUP:
          if (tmr_reg == 16'h0000)
            st_reg <= ST_SHIFT;
          else
            tmr_reg <= tmr_reg - 16'h0001;
        ST_SHIFT:
          if (adv & end_frame)
          begin
            st_reg <= ST_HOLD;
            tmr_reg <= 16'(SCK_HALF);
          end
        ST_HOLD:
          if (tmr_reg == 16'h0000)
          begin
            st_reg <= ST_GAP;
            flash_cs_b_out <= 1'b1;
            tmr_reg <= 16'(DESEL_CYC);
          end
          else
            tmr_reg <= tmr_reg - 16'h0001;
        ST_GAP:
          if (tmr_reg == 16'h0000)
          begin
            st_reg <= ST_IDLE;
            rec_reg <= (rec_reg == 3'd4) ? 3'd0
                     : (rec_reg == 3'd0) ? 3'd0 : rec_reg + 3'd1;
          end
          else
            tmr_reg <= tmr_reg - 16'h0001;
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  // bit shifter, phase loading and data staging
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      ph_reg <= PH_NONE;
      {sh_reg, rx_reg, rdata_reg, wd_reg} <= '0;
      {cnt_reg, en_reg, dum_reg, bytes_reg} <= '0;
      {cw_reg, aw_reg, dw_reg, w_reg} <= {4{3'd1}};
      {op_q_reg, rd_q_reg, rel_reg, crm_req_reg} <= '0;
      {run_reg, wait_reg, rd_valid_reg, wd_full_reg} <= 4'h0;
    end
    else
    begin
      if (apb_wr & (paddr_in == REG_WDATA) & ~wd_full_reg)
      begin
        wd_reg <= pwdata_in[7:0];
        wd_full_reg <= 1'b1;
      end
      if (apb_rd & (paddr_in == REG_RDATA) & rd_took_reg)
        rd_valid_reg <= 1'b0;
      if (launch)
      begin
        ph_reg <= PH_NONE;
        cnt_reg <= 5'd0;
        op_q_reg <= d_op;
        {cw_reg, aw_reg, dw_reg} <= {d_cw, d_aw, d_dw};
        {dum_reg, en_reg, rd_q_reg} <= {d_dum, d_en, d_rd};
        bytes_reg <= d_len;
        crm_req_reg <= cfg_reg[CFG_CRM_BIT];
      end
      if ((st_reg == ST_SHIFT) & sck_rise)
      begin
        cnt_reg <= cnt_reg - 5'd1;
        rx_reg <= rx_next;
        if ((ph_reg == PH_DATA) & rd_q_reg & (cnt_reg == 5'd1))
        begin
          rdata_reg <= rx_next;
          rd_valid_reg <= 1'b1;
        end
      end
      if (adv & stall)
      begin
        wait_reg <= 1'b1;
        run_reg <= 1'b0;
      end
      else if (adv & end_frame)
      begin
        wait_reg <= 1'b0;
        run_reg <= 1'b0;
        ph_reg <= PH_NONE;
      end
      else if (adv)
      begin
        wait_reg <= 1'b0;
        run_reg <= 1'b1;
        if (cnt_reg != 5'd0)
          sh_reg <= sh_reg << w_reg;
        else if ((ph_reg == PH_DATA) & (bytes_reg > 16'h0001))
        begin
          bytes_reg <= bytes_reg - 16'h0001;
          cnt_reg <= clocks_for(6'd8, dw_reg);
          if (!rd_q_reg)
          begin
            sh_reg <= {wd_reg, 24'h000000};
            wd_full_reg <= 1'b0;
          end
        end
        else
        begin
          ph_reg <= sfh_phase_e'(nxt);
          case (nxt)
            5'(PH_CMD):
            begin
              {sh_reg, w_reg, rel_reg} <= {op_q_reg, 24'h0, cw_reg, 1'b0};
              cnt_reg <= clocks_for(6'd8, cw_reg);
            end
            5'(PH_ADDR):
            begin
              {sh_reg, w_reg, rel_reg} <= {addr_reg, 8'h00, aw_reg, 1'b0};
              cnt_reg <= clocks_for(6'd24, aw_reg);
            end
            5'(PH_MODE):
            begin
              sh_reg <= {crm_req_reg ? CRM_MODE_ON : CRM_MODE_OFF, 24'h0};
              {w_reg, rel_reg, cnt_reg} <= {3'd4, 1'b0, MODE_CLK};
            end
            5'(PH_DUMMY):
              {w_reg, rel_reg, cnt_reg} <= {dw_reg, 1'b1, dum_reg};
            default:
            begin
              {w_reg, rel_reg} <= {dw_reg, rd_q_reg};
              cnt_reg <= clocks_for(6'd8, dw_reg);
              if (!rd_q_reg)
              begin
                sh_reg <= {wd_reg, 24'h000000};
                wd_full_reg <= 1'b0;
              end
            end
          endcase
        end
      end
    end
  end

  // lane drive: unused lanes hold the protect and hold pins high
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      flash_dq_out <= DQ_IDLE;
      flash_dq_oe_b_out <= DQ_IDLE;
    end
    else if (flash_cs_b_out | (st_reg == ST_IDLE))
      flash_dq_oe_b_out <= DQ_IDLE;
    else
      case (w_reg)
        3'd4:
        begin
          flash_dq_out <= sh_reg[31:28];
          flash_dq_oe_b_out <= rel_reg ? 4'hf : 4'h0;
        end
        3'd2:
        begin
          flash_dq_out <= {2'b11, sh_reg[31:30]};
          flash_dq_oe_b_out <= rel_reg ? 4'h3 : 4'h0;
        end
        default:
        begin
          flash_dq_out <= {3'b110, sh_reg[31]};
          flash_dq_oe_b_out <= 4'h2;
        end
      endcase
  end

  // shadow of the device's mode, updated when a frame closes
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      {arm_reg, qpi_reg, crm_reg, wel_reg, vsr_reg} <= 5'h00;
    else if (frame_done)
    begin
      arm_reg <= (op_q_reg == OP_RESET_ARM);
      vsr_reg <= (op_q_reg == OP_VSR_EN);
      case (op_q_reg)
        OP_RESET:
          if (arm_reg)
          begin
            // accepted even mid-erase; the device aborts it
            qpi_reg <= 1'b0;
            crm_reg <= 1'b0;
            wel_reg <= 1'b0;
          end
        OP_QUAD_ENTER:
          qpi_reg <= 1'b1;
        OP_QUAD_EXIT:
          if (crm_reg)
            crm_reg <= 1'b0;
          else if (qpi_reg)
            qpi_reg <= 1'b0;
        OP_QUAD_IO:
          crm_reg <= crm_req_reg;
        OP_WRITE_ENABLE_CMD:
          wel_reg <= 1'b1;
        OP_WRDI, OP_PROG, OP_QPROG, OP_SECT_ER, OP_HALF_ER, OP_BLK_ER,
        OP_CHIP_ER1, OP_CHIP_ER2, OP_STAT_WR, OP_STAT3_WR:
          wel_reg <= 1'b0;
        default:
          wel_reg <= wel_reg;
      endcase
    end
  end

  // command launch request and sticky error
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      go_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else
    begin
      if (start)
        go_reg <= 1'b0;
      else if (apb_wr & (paddr_in == REG_CMD) & ~busy
               & ~pwdata_in[CMD_RECOVER_BIT])
        go_reg <= 1'b1;
      // set wins over the software clear
      if (refuse_evt | (apb_wr & (paddr_in == REG_CMD) & busy))
        err_reg <= 1'b1;
      else if (apb_wr & (paddr_in == REG_STAT) & pwdata_in[STAT_ERR_BIT])
        err_reg <= 1'b0;
    end
  end

  // apb register file; read data captured in the setup cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      {prdata_out, pready_out, pslverr_out, rd_took_reg} <= '0;
      addr_reg <= ADDR_RST;
      len_reg <= LEN_RST;
      cfg_reg <= CFG_RST;
      cmd_op_reg <= 8'h00;
    end
    else
    begin
      pready_out <= 1'b1;
      if (apb_setup)
      begin
        pslverr_out <= ~(paddr_in inside {REG_CMD, REG_ADDR, REG_LEN,
                         REG_CFG, REG_WDATA, REG_RDATA, REG_STAT});
        rd_took_reg <= (paddr_in == REG_RDATA) & rd_valid_reg;
        case (paddr_in)
          REG_CMD: prdata_out <= {24'h0, cmd_op_reg};
          REG_ADDR: prdata_out <= {8'h00, addr_reg};
          REG_LEN: prdata_out <= {16'h0000, len_reg};
          REG_CFG: prdata_out <= {29'h0, cfg_reg};
          REG_RDATA: prdata_out <= {24'h0, rdata_reg};
          REG_STAT: prdata_out <= {23'h0, err_reg, vsr_reg, wel_reg,
                                   arm_reg, crm_reg, qpi_reg, rd_valid_reg,
                                   wd_full_reg, busy};
          default: prdata_out <= 32'h00000000;
        endcase
      end
      if (apb_wr & ~busy)
      begin
        if (paddr_in == REG_CMD)
          cmd_op_reg <= pwdata_in[7:0];
        if (paddr_in == REG_ADDR)
          addr_reg <= pwdata_in[23:0];
        if (paddr_in == REG_LEN)
          len_reg <= pwdata_in[15:0];
        if (paddr_in == REG_CFG)
          cfg_reg <= pwdata_in[2:0];
      end
    end
  end
endmodule : sfh_host_ctrl

// [sfh_pkg.sv]
// Purpose: shared constants and types for the serial flash host controller
// Assumes: 250 MHz system clock, flash in SPI mode 0
// Notes: register offsets are byte addresses on the APB slave
package sfh_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_DESEL_NS = 50;
  localparam int T_CS_SETUP_NS = 8;
  localparam int DESEL_CYC = (T_DESEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_SETUP_CYC =
    (T_CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYC = 8;

  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_LEN = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0c;
  localparam logic [7:0] REG_WDATA = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;

  localparam int CMD_RECOVER_BIT = 8;
  localparam int CFG_CRM_BIT = 2;
  localparam int STAT_ERR_BIT = 8;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [15:0] LEN_RST = 16'h0000;
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [3:0] DQ_IDLE = 4'hf;

  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_QPROG = 8'h32;
  localparam logic [7:0] OP_SECT_ER = 8'h20;
  localparam logic [7:0] OP_HALF_ER = 8'h52;
  localparam logic [7:0] OP_BLK_ER = 8'hd8;
  localparam logic [7:0] OP_CHIP_ER1 = 8'hc7;
  localparam logic [7:0] OP_CHIP_ER2 = 8'h60;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_QUAD_ENTER = 8'h38;
  localparam logic [7:0] OP_QUAD_EXIT = 8'hff;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_VSR_EN = 8'h50;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_STAT3_WR = 8'hc0;
  localparam logic [7:0] OP_ID_RES = 8'hab;
  localparam logic [7:0] OP_ID_MFR = 8'h90;

  // mode byte values are arbitrary; device only needs them to differ
  localparam logic [7:0] CRM_MODE_ON = 8'ha0;
  localparam logic [7:0] CRM_MODE_OFF = 8'h00;
  localparam logic [4:0] FAST_DUMMY_CLK = 5'd8;
  localparam logic [4:0] DUAL_IO_DUMMY_CLK = 5'd4;
  localparam logic [4:0] MODE_CLK = 5'd2;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_SHIFT = 5'b00100,
    ST_HOLD = 5'b01000,
    ST_GAP = 5'b10000
  } sfh_state_e;

  typedef enum logic [4:0] {
    PH_NONE = 5'b00000,
    PH_CMD = 5'b00001,
    PH_ADDR = 5'b00010,
    PH_MODE = 5'b00100,
    PH_DUMMY = 5'b01000,
    PH_DATA = 5'b10000
  } sfh_phase_e;

  function automatic logic [1:0] lane_shift(input logic [2:0] w);
    lane_shift = (w == 3'd4) ? 2'd2 : (w == 3'd2) ? 2'd1 : 2'd0;
  endfunction : lane_shift

  function automatic logic [4:0] clocks_for(input logic [5:0] bits,
                                            input logic [2:0] w);
    clocks_for = 5'(bits >> lane_shift(w));
  endfunction : clocks_for

  // status register three dummy field code to clock count
  function automatic logic [4:0] sr3_dummy(input logic [1:0] code);
    case (code)
      2'd0: sr3_dummy = 5'd6;
      2'd1: sr3_dummy = 5'd4;
      2'd2: sr3_dummy = 5'd8;
      default: sr3_dummy = 5'd10;
    endcase
  endfunction : sr3_dummy
endpackage : sfh_pkg

// [sfh_sync.sv]
// Purpose: two-flop synchroniser for flash data pins
// Assumes: inputs asynchronous to clk_sys_in
// Notes: first stage is read by the second stage only
`timescale 1ns/100ps
module sfh_sync
  import sfh_pkg::*;
#(
  parameter int W = 4
)
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : sfh_sync

// [sfh_sck_div.sv]
// Purpose: serial clock divider with edge pulses
// Assumes: run_in only drops while sck is low
// Notes: rise/fall pulses coincide with the sck flop changing
`timescale 1ns/100ps
module sfh_sck_div
  import sfh_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYC
)
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic run_in,
  output logic sck_out,
  output logic rise_out,
  output logic fall_out
);
  logic [7:0] cnt_reg;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      cnt_reg <= 8'h00;
      sck_out <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end
    else if (!run_in)
    begin
      cnt_reg <= 8'h00;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end
    else if (cnt_reg == 8'(HALF - 1))
    begin
      cnt_reg <= 8'h00;
      sck_out <= ~sck_out;
      rise_out <= ~sck_out;
      fall_out <= sck_out;
    end
    else
    begin
      cnt_reg <= cnt_reg + 8'h01;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end
  end
endmodule : sfh_sck_div

// [sfh_host_ctrl_checker.sv]
// Purpose: link timing checks on the flash host controller
// Assumes: serial clock idles low between frames
// Notes: attached by bind below
`timescale 1ns/100ps
module sfh_host_ctrl_checker
  import sfh_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYC
)
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic flash_cs_b_out,
  input wire logic flash_sck_out,
  input wire logic [3:0] flash_dq_out,
  input wire logic [3:0] flash_dq_oe_b_out
);
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  logic odd;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // low count saturates so long idle never wraps
  always_ff @(posedge clk_sys_in)
  begin
    hi_cnt <= (!rst_b_in || !flash_sck_out) ? 8'h0 : hi_cnt + 8'h1;
    lo_cnt <= (!rst_b_in || flash_sck_out) ? 8'h0 :
      lo_cnt + {7'h0, ~&lo_cnt};
  end
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in || flash_cs_b_out)
      odd <= 1'b0;
    else
      odd <= odd ^ (flash_sck_out && hi_cnt == 8'h0);
  end
  a_sck_idle: assert property (flash_cs_b_out |-> !flash_sck_out)
    else $error("clock moved while deselected");
  a_cs_gap: assert property ($rose(flash_cs_b_out) |=> flash_cs_b_out [*8])
    else $error("deselect gap too short");
  a_cs_setup: assert property ($fell(flash_cs_b_out) |-> !flash_sck_out [*2])
    else $error("clock rose too soon after select");
  a_sck_high: assert property ($fell(flash_sck_out) |-> hi_cnt == SCK_HALF)
    else $error("clock high phase wrong");
  a_sck_low: assert property ($rose(flash_sck_out) |-> lo_cnt >= SCK_HALF)
    else $error("clock low phase short");
  a_whole_units: assert property ($rose(flash_cs_b_out) |-> !odd)
    else $error("frame ended on odd clock count");
  a_dq_hold: assert property ($rose(flash_sck_out) |-> $stable(flash_dq_out))
    else $error("data moved at sampling edge");
  a_oe_idle: assert property (flash_cs_b_out [*3] |-> flash_dq_oe_b_out == DQ_IDLE)
    else $error("lanes driven while deselected");
endmodule : sfh_host_ctrl_checker

bind sfh_host_ctrl sfh_host_ctrl_checker #(.SCK_HALF(SCK_HALF)) u_chk(
  .clk_sys_in, .rst_b_in, .flash_cs_b_out, .flash_sck_out,
  .flash_dq_out, .flash_dq_oe_b_out);

// [sfh_flash_model.sv]
// Purpose: behavioural flash decoding opcodes and mode flags
// Assumes: mode 0, lanes resolved by the bench
// Notes: released lanes toggle each clock
`timescale 1ns/100ps
module sfh_flash_model
  import sfh_pkg::*;
(
  input wire logic sck_in,
  input wire logic cs_b_in,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out
);
  logic [7:0] sh;
  int n = 0;
  logic q = 1'b0;
  logic arm = 1'b0;
  logic write_enable_latch = 1'b0;
  logic pat = 1'b0;
  assign dq_out = {4{pat}};
  always @(negedge sck_in) pat <= ~pat;
  always @(negedge cs_b_in) n = 0;
  always @(posedge sck_in)
  begin
    if (!cs_b_in && n < 8)
    begin
      sh = q ? {sh[3:0], dq_in} : {sh[6:0], dq_in[0]};
      n += q ? 4 : 1;
    end
  end
  // partial opcode byte leaves every flag alone
  always @(posedge cs_b_in)
  begin
    if (n == 8)
    begin
      if (sh == OP_RESET && arm)
      begin
        q = 1'b0;
        write_enable_latch = 1'b0;
      end
      arm = sh == OP_RESET_ARM;
      if (sh == OP_QUAD_ENTER) q = 1'b1;
      if (sh == OP_QUAD_EXIT) q = 1'b0;
      if (sh == OP_WRITE_ENABLE_CMD) write_enable_latch = 1'b1;
      if (sh inside {OP_SECT_ER, OP_HALF_ER, OP_BLK_ER, OP_CHIP_ER1,
        OP_CHIP_ER2, OP_PROG, OP_QPROG, OP_STAT_WR, OP_STAT3_WR})
        write_enable_latch = 1'b0;
    end
  end
endmodule : sfh_flash_model

// [sfh_host_ctrl_test.sv]
// Purpose: self-checking bench for the flash host controller
// Assumes: commands carry no data bytes
// Notes: status flags come from an integer model
`timescale 1ns/100ps
module sfh_host_ctrl_test
  import sfh_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0;
  logic [31:0] prdata_out, rd, d;
  logic pready_out, pslverr_out, pe, flash_cs_b_out;
  wire flash_sck_out;
  logic [3:0] flash_dq_out, flash_dq_oe_b_out, m_dq;
  wire [3:0] flash_dq_in;
  logic [7:0] er[9] = '{OP_SECT_ER, OP_HALF_ER, OP_BLK_ER, OP_CHIP_ER1,
    OP_CHIP_ER2, OP_PROG, OP_QPROG, OP_STAT_WR, OP_STAT3_WR};
  logic [7:0] qr[4] = '{OP_READ, OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT};
  int fail_count = 0, n_checks = 0, q = 0, write_enable_latch = 0, arm = 0, err = 0;
  int vsr = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  assign flash_dq_in = (flash_dq_oe_b_out & m_dq) |
    (~flash_dq_oe_b_out & flash_dq_out);
  sfh_host_ctrl #(.SCK_HALF(4)) i_dut(.clk_sys_in, .rst_b_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .flash_cs_b_out, .flash_sck_out,
    .flash_dq_out, .flash_dq_oe_b_out, .flash_dq_in);
  sfh_flash_model i_fm(.sck_in(flash_sck_out), .cs_b_in(flash_cs_b_out),
    .dq_in(flash_dq_in), .dq_out(m_dq));
  task finish_test;
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1) @(posedge clk_sys_in);
    rd = prdata_out;
    pe = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  // busy may lag the command write by a cycle or two
  task stat;
    repeat (2) @(posedge clk_sys_in);
    apb(1'b0, REG_STAT, '0);
    while (rd[0] !== 1'b0) apb(1'b0, REG_STAT, '0);
    d = (err << 8) | (vsr << 7) | (write_enable_latch << 6) | (arm << 5) | (q << 3);
    chk(rd & 32'h1e8, d);
    chk(i_fm.q, q);
    chk(i_fm.write_enable_latch, write_enable_latch);
    chk(i_fm.arm, arm);
  endtask : stat
  task op(input logic [7:0] c);
    apb(1'b1, REG_CMD, {24'h0, c});
    if (q && c inside {qr})
      err = 1;
    else if (!write_enable_latch && c inside {er} && !(vsr && c == OP_STAT_WR))
      err = 1;
    else
    begin
      if (c == OP_WRITE_ENABLE_CMD) write_enable_latch = 1;
      if (c inside {er} || (c == OP_RESET && arm)) write_enable_latch = 0;
      if (c == OP_QUAD_ENTER) q = 1;
      if (c == OP_QUAD_EXIT || (c == OP_RESET && arm)) q = 0;
      arm = c == OP_RESET_ARM;
      vsr = c == OP_VSR_EN;
    end
    stat();
  endtask : op
  task clr;
    apb(1'b1, REG_STAT, 32'h100);
    err = 0;
    stat();
  endtask : clr
  initial
  begin
    void'($urandom(32'hc686c8ed));
    repeat (3) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    foreach (er[i])
    begin
      op(OP_WRITE_ENABLE_CMD);
      op(er[i]);
    end
    op(OP_SECT_ER);
    clr();
    op(OP_VSR_EN);
    op(OP_STAT_WR);
    op(OP_QUAD_EXIT);
    op(OP_RESET_ARM);
    op(OP_WRITE_ENABLE_CMD);
    op(OP_RESET);
    op(OP_QUAD_ENTER);
    foreach (qr[i]) op(qr[i]);
    clr();
    op(OP_RESET_ARM);
    op(OP_RESET);
    op(OP_QUAD_ENTER);
    op(OP_QUAD_EXIT);
    op(OP_QUAD_ENTER);
    op(OP_WRITE_ENABLE_CMD);
    apb(1'b1, REG_CMD, 32'h100);
    q = 0;
    write_enable_latch = 0;
    arm = 0;
    stat();
    repeat (4)
    begin
      d = $urandom;
      apb(1'b1, REG_ADDR, d);
      apb(1'b0, REG_ADDR, '0);
      chk(rd, d & 32'hffffff);
    end
    apb(1'b0, 8'h1c, '0);
    chk({31'h0, pe}, 32'h1);
    chk(rd, 32'h0);
    finish_test();
  end
  initial
  begin
    #300000;
    fail_count++;
    finish_test();
  end
endmodule : sfh_host_ctrl_test
